// *** common/dhif_pkg.sv ***
// Constants and types shared by the display host interface front end
//------------------------------------------------------------------------------
// Overview of operation
// R1: Hard reset low initialises controller to default
// R2: Host keeps hard reset high in operation
// R3: Bus activity counts only while chip select low
// R4: Qualifier high means data, low means command
// R5: In I2C mode qualifier selects slave address
// R6: Enable-strobe mode cycle starts on enable rise
// R7: Read/write select high reads, low writes
// R8: Separate-strobe read starts on read strobe low
// R9: Separate-strobe write starts on write strobe low
// R10: Serial or I2C modes ground both strobe inputs
// R11: Eight-bit bus driven on reads, sampled on writes
// R12: Serial data on bit 1, clock on bit 0
// R13: I2C: data out 2, in 1, clock 0
// R14: Board grounds unused data pins except serial bit 2
// R15: Protocol select pins choose mode via parameter map
//------------------------------------------------------------------------------
package dhif_pkg;

	//--------------------------------------------------------------------------
	// Widths and depths
	//--------------------------------------------------------------------------
	localparam int DATA_W = 8; // Host data bus width
	localparam int FIFO_DEPTH = 8; // Words buffered toward the core
	localparam int PIN_W = 16; // Width of the synchronised pin bundle

	//--------------------------------------------------------------------------
	// Bit positions in the synchronised pin bundle
	//--------------------------------------------------------------------------
	localparam int PIN_SEL_LSB = 13; // Protocol select bits 15..13
	localparam int PIN_HARD_RST = 12; // Hard reset, active low
	localparam int PIN_CS = 11; // Chip select, active low
	localparam int PIN_DC = 10; // Data/command qualifier
	localparam int PIN_EN_RD = 9; // Enable or read strobe
	localparam int PIN_RW_WR = 8; // Read/write select or write strobe
	localparam logic [PIN_W-1:0] PIN_IDLE = 16'h1800; // Reset value: deselected, no reset

	//--------------------------------------------------------------------------
	// Data bus bit roles in serial and I2C modes
	//--------------------------------------------------------------------------
	localparam int SER_CLK_BIT = 0; // Serial clock pin
	localparam int SER_DATA_BIT = 1; // Serial data input pin
	localparam int I2C_SCL_BIT = 0; // I2C clock in
	localparam int I2C_SDA_IN_BIT = 1; // I2C data in
	localparam int I2C_SDA_OUT_BIT = 2; // I2C data out

	//--------------------------------------------------------------------------
	// Counts and reset values
	//--------------------------------------------------------------------------
	localparam logic [2:0] SER_LAST_BIT = 3'h7; // Index of the eighth serial bit
	localparam logic [3:0] I2C_BYTE_BITS = 4'h8; // Bits in one I2C byte
	localparam logic [7:0] BYTE_RST = 8'h00; // Cleared byte value
	localparam int CTRL_CO_BIT = 7; // Continuation bit of I2C control byte
	localparam int CTRL_DC_BIT = 6; // Data/command bit of I2C control byte
	localparam logic [5:0] I2C_ADDR_BASE = 6'h15; // Arbitrary upper address bits

	//--------------------------------------------------------------------------
	// Default protocol select encodings
	//--------------------------------------------------------------------------
	localparam logic [2:0] SEL_PAR_E = 3'h0; // Enable-strobe parallel
	localparam logic [2:0] SEL_PAR_S = 3'h1; // Separate-strobe parallel
	localparam logic [2:0] SEL_SER = 3'h2; // Clocked serial
	localparam logic [2:0] SEL_I2C = 3'h3; // I2C

	//--------------------------------------------------------------------------
	// Types
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic isData; // High for display data, low for command
		logic [DATA_W-1:0] byteVal; // Transferred byte
	} dhif_word_t;

	typedef enum logic [4:0] {
		MODE_NONE = 5'b00001,
		MODE_PAR_E = 5'b00010,
		MODE_PAR_S = 5'b00100,
		MODE_SER = 5'b01000,
		MODE_I2C = 5'b10000
	} dhif_mode_t;

	typedef enum logic [2:0] {
		I2C_IDLE = 3'b001,
		I2C_RECV = 3'b010,
		I2C_ACK = 3'b100
	} dhif_i2c_state_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b001,
		PH_CTRL = 3'b010,
		PH_DATA = 3'b100
	} dhif_phase_t;

endpackage : dhif_pkg

// *** logic/dhif_fifo.sv ***
// Synchronous word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dhif_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	//--------------------------------------------------------------------------
	// Storage and pointers
	//--------------------------------------------------------------------------
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Word store
	logic [AW-1:0] wrPtr_r; // Next slot to fill
	logic [AW-1:0] rdPtr_r; // Oldest slot
	logic [CW-1:0] count_r; // Words held

	wire logic doWrite = inValid & inReady; // Word accepted
	wire logic doRead = outValid & outReady; // Word taken

	// Honest full and empty from the word count
	assign inReady = (count_r != FULL_CNT);
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];

	//--------------------------------------------------------------------------
	// Pointer and count update; clear empties the buffer
	//--------------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else if (clr)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			wrPtr_r <= doWrite ? ((wrPtr_r == LAST_IDX) ? '0 : wrPtr_r + 1'b1) : wrPtr_r;
			rdPtr_r <= doRead ? ((rdPtr_r == LAST_IDX) ? '0 : rdPtr_r + 1'b1) : rdPtr_r;
			count_r <= count_r + CW'(doWrite) - CW'(doRead);
		end
	end

	// Word store, no reset needed
	always_ff @(posedge sys_clk)
	begin
		if (doWrite)
		begin
			mem[wrPtr_r] <= inData;
		end
	end

endmodule : dhif_fifo
`default_nettype wire

// *** logic/dhif_front_end.sv ***
// Host interface front end: parallel, serial and I2C host ports into a FIFO
`timescale 1ns/1ns
`default_nettype none
module dhif_front_end #(
	parameter logic [2:0] SEL_CODE_PAR_E = dhif_pkg::SEL_PAR_E,
	parameter logic [2:0] SEL_CODE_PAR_S = dhif_pkg::SEL_PAR_S,
	parameter logic [2:0] SEL_CODE_SER = dhif_pkg::SEL_SER,
	parameter logic [2:0] SEL_CODE_I2C = dhif_pkg::SEL_I2C,
	parameter int FIFO_DEPTH = dhif_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic serialClk,
	input wire logic hardReset_b,
	input wire logic chipSel_b,
	input wire logic dataCmd,
	input wire logic enRd,
	input wire logic rwWr,
	input wire logic [2:0] protocolSelect,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic [7:0] hostDataOe_b,
	output logic ctlInit,
	output logic hostBusy,
	output logic readReq,
	input wire logic [7:0] readData,
	output logic outValid,
	input wire logic outReady,
	output dhif_pkg::dhif_word_t outWord
);
	//--------------------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------------------
	wire logic [dhif_pkg::PIN_W-1:0] pinRaw = {protocolSelect, hardReset_b, chipSel_b,
		dataCmd, enRd, rwWr, hostDataIn};
	logic [dhif_pkg::PIN_W-1:0] pinS1_r; // First stage, read only by second
	logic [dhif_pkg::PIN_W-1:0] pinS2_r; // Stable synchronised pins
	logic [dhif_pkg::PIN_W-1:0] pinS3_r; // Delayed copy for edge detection

	// Two flip-flops before any logic, third for edges
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinS1_r <= dhif_pkg::PIN_IDLE;
			pinS2_r <= dhif_pkg::PIN_IDLE;
			pinS3_r <= dhif_pkg::PIN_IDLE;
		end
		else
		begin
			pinS1_r <= pinRaw;
			pinS2_r <= pinS1_r;
			pinS3_r <= pinS2_r;
		end
	end

	// Named views of the synchronised pins
	wire logic [2:0] selS = pinS2_r[dhif_pkg::PIN_SEL_LSB +: 3];
	wire logic hardRstActive = ~pinS2_r[dhif_pkg::PIN_HARD_RST];
	wire logic csLow = ~pinS2_r[dhif_pkg::PIN_CS];
	wire logic dcS = pinS2_r[dhif_pkg::PIN_DC];
	wire logic enS = pinS2_r[dhif_pkg::PIN_EN_RD];
	wire logic enP = pinS3_r[dhif_pkg::PIN_EN_RD];
	wire logic rwS = pinS2_r[dhif_pkg::PIN_RW_WR];
	wire logic rwP = pinS3_r[dhif_pkg::PIN_RW_WR];
	wire logic [7:0] dataS = pinS2_r[7:0];
	wire logic sclS = pinS2_r[dhif_pkg::I2C_SCL_BIT];
	wire logic sclP = pinS3_r[dhif_pkg::I2C_SCL_BIT];
	wire logic sdaS = pinS2_r[dhif_pkg::I2C_SDA_IN_BIT];
	wire logic sdaP = pinS3_r[dhif_pkg::I2C_SDA_IN_BIT];

	//--------------------------------------------------------------------------
	// Mode decode from the static select pins
	//--------------------------------------------------------------------------
	dhif_pkg::dhif_mode_t mode_r; // Active host port
	dhif_pkg::dhif_mode_t modeNxt; // Decoded select value

	// Parameterised select map, unknown codes leave all ports idle
	assign modeNxt = (selS == SEL_CODE_PAR_E) ? dhif_pkg::MODE_PAR_E : // R15
		(selS == SEL_CODE_PAR_S) ? dhif_pkg::MODE_PAR_S :
		(selS == SEL_CODE_SER) ? dhif_pkg::MODE_SER :
		(selS == SEL_CODE_I2C) ? dhif_pkg::MODE_I2C : dhif_pkg::MODE_NONE;

	wire logic modeE = (mode_r == dhif_pkg::MODE_PAR_E);
	wire logic modeSep = (mode_r == dhif_pkg::MODE_PAR_S);
	wire logic modePar = modeE | modeSep;
	wire logic modeSer = (mode_r == dhif_pkg::MODE_SER);
	wire logic modeI2c = (mode_r == dhif_pkg::MODE_I2C);

	// Mode register and controller initialisation level
	logic ctlInit_r; // High while hard reset is held
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_r <= dhif_pkg::MODE_NONE;
			ctlInit_r <= 1'b1;
		end
		else
		begin
			mode_r <= modeNxt;
			ctlInit_r <= hardRstActive; // R1
		end
	end
	assign ctlInit = ctlInit_r;

	//--------------------------------------------------------------------------
	// Parallel port: strobe decoding
	//--------------------------------------------------------------------------
	wire logic eRise = enS & ~enP; // Enable strobe rises
	wire logic eFall = ~enS & enP; // Enable strobe falls
	wire logic rdFall = eFall; // Read strobe asserted
	wire logic rdRise = eRise; // Read strobe released
	wire logic wrFall = ~rwS & rwP; // Write strobe asserted
	wire logic wrRise = rwS & ~rwP; // Write strobe released

	// Cycle starts, each gated by chip select
	wire logic eStart = modeE & csLow & eRise & ~hardRstActive; // R6 R3
	wire logic rdStartE = eStart & rwS; // R7
	wire logic wrStartE = eStart & ~rwS; // R7
	wire logic rdStartS = modeSep & csLow & rdFall & ~hardRstActive; // R8 R3
	wire logic wrStartS = modeSep & csLow & wrFall & ~hardRstActive; // R9 R3
	wire logic rdStart = rdStartE | rdStartS;
	wire logic wrStart = wrStartE | wrStartS;
	wire logic rdEnd = modeE ? eFall : rdRise;
	wire logic wrEnd = modeE ? eFall : wrRise;

	logic pendWr_r; // Write cycle in progress
	logic driveRd_r; // Read cycle in progress, bus driven
	logic [7:0] hostDataOut_r; // Byte presented on reads

	// Write cycles latch the bus when the strobe ends
	wire logic parPush = pendWr_r & wrEnd & csLow; // R11
	assign readReq = rdStart;

	// Cycle tracking; deselect or hard reset abandons a cycle
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pendWr_r <= 1'b0;
			driveRd_r <= 1'b0;
		end
		else if (!csLow || hardRstActive)
		begin
			pendWr_r <= 1'b0; // R3
			driveRd_r <= 1'b0;
		end
		else
		begin
			pendWr_r <= wrStart | (pendWr_r & ~wrEnd);
			driveRd_r <= rdStart | (driveRd_r & ~rdEnd);
		end
	end

	// Read byte register, zero in I2C so the acknowledge drives low
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hostDataOut_r <= dhif_pkg::BYTE_RST;
		end
		else
		begin
			hostDataOut_r <= modeI2c ? dhif_pkg::BYTE_RST :
				(rdStart ? readData : hostDataOut_r);
		end
	end
	assign hostDataOut = hostDataOut_r;

	//--------------------------------------------------------------------------
	// Serial port: link clock domain
	//--------------------------------------------------------------------------
	wire logic linkArst_b = rst_b & ~chipSel_b; // Deselect ends the frame
	logic [2:0] bitCnt_r; // Bits taken in this byte
	logic [6:0] serShift_r; // Partial byte, MSB first
	logic [7:0] holdByte_r; // Completed byte for the core side
	logic holdDc_r; // Qualifier taken with the last bit
	logic serTog_r; // Flips once per completed byte

	// Shift in on rising serial clock, only while selected
	always_ff @(posedge serialClk or negedge linkArst_b)
	begin
		if (!linkArst_b)
		begin
			bitCnt_r <= 3'h0; // R3
			serShift_r <= 7'h00;
		end
		else
		begin
			bitCnt_r <= bitCnt_r + 3'h1;
			serShift_r <= {serShift_r[5:0], hostDataIn[dhif_pkg::SER_DATA_BIT]}; // R12
		end
	end

	// Hand the finished byte over and toggle the event flag
	always_ff @(posedge serialClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			holdByte_r <= dhif_pkg::BYTE_RST;
			holdDc_r <= 1'b0;
			serTog_r <= 1'b0;
		end
		else if (bitCnt_r == dhif_pkg::SER_LAST_BIT)
		begin
			holdByte_r <= {serShift_r, hostDataIn[dhif_pkg::SER_DATA_BIT]}; // R12
			holdDc_r <= dataCmd; // R4
			serTog_r <= ~serTog_r;
		end
	end

	// Toggle crossing into the system clock
	logic [2:0] togSync_r; // Stage 0 read only by stage 1
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			togSync_r <= 3'h0;
		end
		else
		begin
			togSync_r <= {togSync_r[1:0], serTog_r};
		end
	end
	wire logic serPush = modeSer & (togSync_r[2] ^ togSync_r[1]) & ~hardRstActive;

	//--------------------------------------------------------------------------
	// I2C port: oversampled slave, write only
	//--------------------------------------------------------------------------
	wire logic i2cActive = modeI2c & csLow & ~hardRstActive; // R3
	wire logic sclRise = sclS & ~sclP;
	wire logic sclFall = ~sclS & sclP;
	wire logic i2cStart = sclS & sclP & sdaP & ~sdaS; // Data falls, clock high
	wire logic i2cStop = sclS & sclP & ~sdaP & sdaS; // Data rises, clock high

	dhif_pkg::dhif_i2c_state_t iState_r, iStateNxt;
	dhif_pkg::dhif_phase_t iPhase_r, iPhaseNxt;
	logic [3:0] iBitCnt_r, iBitCntNxt; // Bits of current byte
	logic [7:0] iShift_r, iShiftNxt; // Byte being received
	logic iDc_r, iDcNxt; // Qualifier from control byte
	logic iCo_r, iCoNxt; // Another control byte follows
	logic ackDrive_r, ackDriveNxt; // Pull data low for acknowledge

	// Address compare uses the qualifier pin as the low address bit
	wire logic addrMatch = (iShift_r[7:1] == {dhif_pkg::I2C_ADDR_BASE, dcS}) // R5
		& ~iShift_r[0];
	wire logic byteDone = (iState_r == dhif_pkg::I2C_RECV) & sclFall
		& (iBitCnt_r == dhif_pkg::I2C_BYTE_BITS);
	wire logic i2cPush = byteDone & (iPhase_r == dhif_pkg::PH_DATA) & i2cActive; // R3

	// Next-state logic of the I2C receiver
	always_comb
	begin
		iStateNxt = iState_r;
		iPhaseNxt = iPhase_r;
		iBitCntNxt = iBitCnt_r;
		iShiftNxt = iShift_r;
		iDcNxt = iDc_r;
		iCoNxt = iCo_r;
		ackDriveNxt = ackDrive_r;
		case (iState_r)
			dhif_pkg::I2C_IDLE:
			begin
				ackDriveNxt = 1'b0;
			end
			dhif_pkg::I2C_RECV:
			begin
				// Sample data on clock rise
				if (sclRise)
				begin
					iShiftNxt = {iShift_r[6:0], sdaS}; // R13
					iBitCntNxt = iBitCnt_r + 4'h1;
				end
				// Byte complete: acknowledge or drop off the bus
				if (byteDone)
				begin
					if (iPhase_r == dhif_pkg::PH_ADDR && !addrMatch)
					begin
						iStateNxt = dhif_pkg::I2C_IDLE;
					end
					else
					begin
						iStateNxt = dhif_pkg::I2C_ACK;
						ackDriveNxt = 1'b1; // R13
					end
					if (iPhase_r == dhif_pkg::PH_CTRL)
					begin
						iDcNxt = iShift_r[dhif_pkg::CTRL_DC_BIT];
						iCoNxt = iShift_r[dhif_pkg::CTRL_CO_BIT];
					end
				end
			end
			dhif_pkg::I2C_ACK:
			begin
				// Release data after the acknowledge clock
				if (sclFall)
				begin
					iStateNxt = dhif_pkg::I2C_RECV;
					ackDriveNxt = 1'b0;
					iBitCntNxt = 4'h0;
					iPhaseNxt = (iPhase_r == dhif_pkg::PH_DATA && !iCo_r) ?
						dhif_pkg::PH_DATA : ((iPhase_r == dhif_pkg::PH_CTRL) ?
						dhif_pkg::PH_DATA : dhif_pkg::PH_CTRL);
				end
			end
			default:
			begin
				iStateNxt = dhif_pkg::I2C_IDLE;
				ackDriveNxt = 1'b0;
			end
		endcase
		// Start restarts address phase, stop or deselect idles
		if (!i2cActive || i2cStop)
		begin
			iStateNxt = dhif_pkg::I2C_IDLE;
			ackDriveNxt = 1'b0;
		end
		else if (i2cStart)
		begin
			iStateNxt = dhif_pkg::I2C_RECV;
			iPhaseNxt = dhif_pkg::PH_ADDR;
			iBitCntNxt = 4'h0;
			ackDriveNxt = 1'b0;
		end
	end

	// I2C receiver registers
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			iState_r <= dhif_pkg::I2C_IDLE;
			iPhase_r <= dhif_pkg::PH_ADDR;
			iBitCnt_r <= 4'h0;
			iShift_r <= dhif_pkg::BYTE_RST;
			iDc_r <= 1'b0;
			iCo_r <= 1'b0;
			ackDrive_r <= 1'b0;
		end
		else
		begin
			iState_r <= iStateNxt;
			iPhase_r <= iPhaseNxt;
			iBitCnt_r <= iBitCntNxt;
			iShift_r <= iShiftNxt;
			iDc_r <= iDcNxt;
			iCo_r <= iCoNxt;
			ackDrive_r <= ackDriveNxt;
		end
	end

	//--------------------------------------------------------------------------
	// Data bus output enables, low while driving
	//--------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < dhif_pkg::DATA_W; gi++)
		begin : gOe
			assign hostDataOe_b[gi] = ~((modePar & driveRd_r) // R11
				| ((gi == dhif_pkg::I2C_SDA_OUT_BIT) & modeI2c & ackDrive_r)); // R13
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Word merge into the FIFO
	//--------------------------------------------------------------------------
	dhif_pkg::dhif_word_t pushWord; // Word from the active port
	wire logic pushValid = parPush | serPush | i2cPush;
	wire logic fifoInReady;

	// Qualifier marks data or command for parallel and serial
	assign pushWord = parPush ? {dcS, dataS} : // R4
		(serPush ? {holdDc_r, holdByte_r} : // R4
		{iDc_r, iShift_r});
	assign hostBusy = ~fifoInReady;

	dhif_fifo #(
		.WIDTH($bits(dhif_pkg::dhif_word_t)),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clr(hardRstActive), // R1
		.inValid(pushValid),
		.inReady(fifoInReady),
		.inData(pushWord),
		.outValid(outValid),
		.outReady(outReady),
		.outData(outWord)
	);

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	sequence eWriteStart;
		modeE && csLow && eRise && !rwS && !hardRstActive;
	endsequence

	sequence eWriteEnd;
		csLow && eFall;
	endsequence

	hard_rst_init_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
		hardRstActive |-> ##1 ctlInit ##1 !outValid)
		else $error("hard reset did not initialise");

	cs_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
		!csLow |-> !readReq && !parPush && !i2cPush)
		else $error("activity accepted while deselected");

	e_write_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
		eWriteStart |=> pendWr_r)
		else $error("enable-strobe write not started");

	e_write_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
		(pendWr_r && modeE && !hardRstActive) ##0 eWriteEnd |-> parPush ##1 outValid)
		else $error("enable-strobe write not taken");

	e_read_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
		(modeE && csLow && eRise && rwS && !hardRstActive) |-> readReq ##1 driveRd_r)
		else $error("enable-strobe read not started");

	sep_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
		(modeSep && csLow && rdFall && !hardRstActive) |-> readReq ##1 !hostDataOe_b[0])
		else $error("separate-strobe read not driven");

	sep_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
		(modeSep && csLow && wrFall && !hardRstActive) |=> pendWr_r)
		else $error("separate-strobe write not started");

	dc_route_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
		parPush && !outValid && !hardRstActive |=> outWord == {$past(dcS), $past(dataS)})
		else $error("qualifier not carried with byte");

	bus_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
		!hostDataOe_b[7] |-> modePar && driveRd_r && ($past(readReq) || $stable(hostDataOut)))
		else $error("bus driven outside a read");

	i2c_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
		(byteDone && iPhase_r == dhif_pkg::PH_ADDR && i2cActive && !i2cStop && !i2cStart)
		|=> ackDrive_r == $past(addrMatch))
		else $error("address select bit not honoured");

	ser_byte_a: assert property (@(posedge serialClk) disable iff (!linkArst_b) // R12
		bitCnt_r == dhif_pkg::SER_LAST_BIT |=> serTog_r != $past(serTog_r))
		else $error("serial byte not handed over");

endmodule : dhif_front_end
`default_nettype wire

// *** sim/dhif_host_model.sv ***
// Host bus model that drives the display interface pins
`timescale 1ns/1ns
`default_nettype none
module dhif_host_model (
	input wire logic sys_clk,
	output logic serialClk,
	output logic chipSel_b,
	output logic dataCmd,
	output logic enRd,
	output logic rwWr,
	output logic [7:0] hostDataIn
);
	// Deselected, link clock still, strobes and unused bus pins grounded
	initial {serialClk, chipSel_b, dataCmd, enRd, rwWr, hostDataIn} = 13'h0800;
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : hold
	// Strobes to the idle level of a mode before it is selected
	task automatic park(input logic sep);
		{enRd, rwWr} = {sep, sep};
		hold(4);
	endtask : park
	// One strobed byte, everything held through the strobe
	task automatic xfer(input logic sep, input logic rd, input logic cs, input logic dc,
		input logic [7:0] b);
		chipSel_b = cs;
		dataCmd = dc;
		hostDataIn = b;
		{enRd, rwWr} = sep ? 2'b11 : {1'b0, rd};
		hold(4);
		{enRd, rwWr} = sep ? {~rd, rd} : {1'b1, rd};
		hold(4);
		{enRd, rwWr} = sep ? 2'b11 : {1'b0, rd};
		hold(4);
		chipSel_b = 1'b1;
		hostDataIn = ~b;
		hold(1);
	endtask : xfer
	// One serial byte, MSB first; the 64 ns link clock runs only in the frame
	task automatic ser(input logic dc, input logic [7:0] b);
		chipSel_b = 1'b0;
		dataCmd = dc;
		for (int i = 7; i >= 0; i--)
		begin
			hostDataIn = {6'h00, b[i], 1'b0};
			#20 {serialClk, hostDataIn[0]} = 2'b11;
			#32 {serialClk, hostDataIn[0]} = 2'b00;
			#12;
		end
		hostDataIn[1] = ~b[0];
		#300 chipSel_b = 1'b1;
		#64;
	endtask : ser
	// One I2C write: address, control, data; host releases each acknowledge slot
	task automatic i2c(input logic sa, input logic [7:0] a, input logic [7:0] ctl,
		input logic [7:0] b);
		logic [26:0] f;
		f = {a, 1'b1, ctl, 1'b1, b, 1'b1};
		dataCmd = sa;
		chipSel_b = 1'b0;
		hostDataIn = 8'h03;
		hold(6);
		hostDataIn[1] = 1'b0;
		hold(6);
		for (int i = 26; i >= 0; i--)
		begin
			hostDataIn[1:0] = {f[i], 1'b0};
			hold(6);
			hostDataIn[0] = 1'b1;
			hold(6);
		end
		hostDataIn[1:0] = 2'b00;
		hold(6);
		hostDataIn[0] = 1'b1;
		hold(6);
		hostDataIn[1] = 1'b1;
		hold(6);
		chipSel_b = 1'b1;
	endtask : i2c
endmodule : dhif_host_model
`default_nettype wire

// *** sim/dhif_front_end_tb.sv ***
// Self-checking bench for the display host interface front end
`timescale 1ns/1ns
`default_nettype none
module dhif_front_end_tb;
	logic sys_clk, rst_b, hardReset_b, serialClk, chipSel_b, dataCmd, enRd, rwWr;
	logic [2:0] protocolSelect;
	logic [7:0] hostDataIn, hostDataOut, hostDataOe_b, readData;
	logic ctlInit, hostBusy, readReq, outValid, outReady;
	dhif_pkg::dhif_word_t outWord;
	int error_cnt = 0;
	int n_checks = 0;
	// Rows: {separate strobes, qualifier, byte} beside the expected word
	logic [9:0] rowIn [4] = '{10'h1A5, 10'h03C, 10'h300, 10'h2FF};
	logic [8:0] rowExp [4] = '{9'h1A5, 9'h03C, 9'h100, 9'h0FF};
	dhif_front_end dhif_front_end_i (.sys_clk(sys_clk), .rst_b(rst_b), .serialClk(serialClk),
		.hardReset_b(hardReset_b), .chipSel_b(chipSel_b), .dataCmd(dataCmd), .enRd(enRd),
		.rwWr(rwWr), .protocolSelect(protocolSelect), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOe_b(hostDataOe_b), .ctlInit(ctlInit),
		.hostBusy(hostBusy), .readReq(readReq), .readData(readData), .outValid(outValid),
		.outReady(outReady), .outWord(outWord));
	dhif_host_model dhif_host_model_i (.sys_clk(sys_clk), .serialClk(serialClk),
		.chipSel_b(chipSel_b), .dataCmd(dataCmd), .enRd(enRd), .rwWr(rwWr),
		.hostDataIn(hostDataIn));
	// 50 ns system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : hold
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Waits a bounded time for a word, compares it, then takes it
	task automatic pop(input logic [8:0] e);
		int k;
		k = 0;
		while (outValid !== 1'b1 && k < 40)
		begin
			hold(1);
			k++;
		end
		chk("popValid", 9'h001, {8'h00, outValid});
		chk("outWord", e, outWord);
		outReady = 1'b1;
		hold(1);
		outReady = 1'b0;
	endtask : pop
	task automatic mode(input logic sep, input logic [2:0] code);
		dhif_host_model_i.park(sep);
		protocolSelect = code;
		hold(4);
	endtask : mode
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// Watchdog well beyond the expected run
	initial
	begin
		#400000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		{rst_b, hardReset_b, outReady, readData} = 11'h200;
		protocolSelect = dhif_pkg::SEL_PAR_E;
		hold(12);
		chk("resetOe", 9'h0FF, {1'b0, hostDataOe_b});
		chk("resetValid", 9'h000, {8'h00, outValid});
		rst_b = 1'b1;
		hold(4);
		// Table of writes in both parallel modes
		for (int r = 0; r < 4; r++)
		begin
			mode(rowIn[r][9], rowIn[r][9] ? dhif_pkg::SEL_PAR_S : dhif_pkg::SEL_PAR_E);
			dhif_host_model_i.xfer(rowIn[r][9], 1'b0, 1'b0, rowIn[r][8], rowIn[r][7:0]);
			pop(rowExp[r]);
		end
		// Reads in both parallel modes: bus driven only while reading
		for (int s = 0; s < 2; s++)
		begin
			mode(s[0], s[0] ? dhif_pkg::SEL_PAR_S : dhif_pkg::SEL_PAR_E);
			readData = 8'h5A ^ s[7:0];
			fork
				dhif_host_model_i.xfer(s[0], 1'b1, 1'b0, 1'b1, 8'h00);
				begin
					wait (readReq === 1'b1);
					hold(1);
					chk("readBus", {1'b1, readData}, {hostDataOe_b === 8'h00, hostDataOut});
				end
			join
			chk("readOff", 9'h0FF, {1'b0, hostDataOe_b});
		end
		// A write while deselected leaves nothing behind
		dhif_host_model_i.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'h77);
		hold(8);
		chk("deselected", 9'h000, {8'h00, outValid});
		// Two serial bytes back to back, data then command
		mode(1'b0, dhif_pkg::SEL_SER);
		dhif_host_model_i.ser(1'b1, 8'hC3);
		dhif_host_model_i.ser(1'b0, 8'h81);
		pop(9'h1C3);
		pop(9'h081);
		// I2C writes: matching select bit, then a mismatching one left unanswered
		mode(1'b0, dhif_pkg::SEL_I2C);
		dhif_host_model_i.i2c(1'b1, {dhif_pkg::I2C_ADDR_BASE, 2'b10}, 8'h40, 8'h96);
		pop(9'h196);
		dhif_host_model_i.i2c(1'b0, {dhif_pkg::I2C_ADDR_BASE, 2'b10}, 8'h40, 8'h69);
		chk("i2cRefused", 9'h000, {8'h00, outValid});
		// Fill the buffer past full with the core stalled, then drain it
		mode(1'b0, dhif_pkg::SEL_PAR_E);
		for (int i = 0; i <= dhif_pkg::FIFO_DEPTH; i++)
			dhif_host_model_i.xfer(1'b0, 1'b0, 1'b0, 1'b1, i[7:0]);
		chk("busy", 9'h001, {8'h00, hostBusy});
		for (int i = 0; i < dhif_pkg::FIFO_DEPTH; i++)
			pop({1'b1, i[7:0]});
		hold(2);
		chk("drained", 9'h000, {8'h00, outValid});
		// Hard reset pin
		hardReset_b = 1'b0;
		hold(6);
		chk("initHigh", 9'h001, {8'h00, ctlInit});
		hardReset_b = 1'b1;
		hold(6);
		chk("initLow", 9'h000, {8'h00, ctlInit});
		report_and_stop();
	end
endmodule : dhif_front_end_tb
`default_nettype wire
